//--- rtl/stc_map.svh
`ifndef STC_MAP_SVH
`define STC_MAP_SVH
// register byte offsets on the wishbone bus
`define STC_OFS_CTRL1   4'h0
`define STC_OFS_STATUS  4'h4
`define STC_OFS_DATA    4'h8
`define STC_OFS_DIV     4'hc
// second control register sits in a spare slot of the 4-bit address space
`define STC_OFS_CTRL2   4'h1
// first control register fields
`define STC_C1_LSB_FIRST_SELECT    0
`define STC_C1_SELECT_OUTPUT_ENABLE     1
`define STC_C1_CPHA     2
`define STC_C1_CPOL     3
`define STC_C1_MASTER_SELECT     4
`define STC_C1_TXIE     5
`define STC_C1_EN       6
`define STC_C1_RXIE     7
// second control register field
`define STC_C2_FAULT_ENABLE   4
// status register fields
`define STC_ST_RXFULL   7
`define STC_ST_TXEMPTY  5
`define STC_ST_MODE_FAULT_FLAG     4
// reset values
`define STC_CTRL1_RST   8'h04
`define STC_CTRL2_RST   8'h00
`define STC_DIV_RST     8'h04
// bits per transfer and serial half periods per byte
`define STC_BITS        4'h8
`define STC_HALVES      5'h10
`endif

//--- rtl/stc_pkg.sv
package stc_pkg;
    // wishbone request from the master
    typedef struct packed {
        logic       cyc;
        logic       stb;
        logic       we;
        logic [3:0] adr;
        logic [3:0] sel;
        logic [7:0] dat;
    } stc_wb_req_type;
    // serial pin bundle, each with output enable
    typedef struct packed {
        logic sck;
        logic sckOe;
        logic mosi;
        logic mosiOe;
        logic miso;
        logic misoOe;
        logic ssN;
        logic ssNOe;
    } stc_pins_out_type;
    // engine states
    typedef enum logic [1:0] {
        STC_IDLE  = 2'b00,
        STC_LEAD  = 2'b01,
        STC_SHIFT = 2'b10,
        STC_TAIL  = 2'b11
    } stc_state_type;
endpackage

//--- rtl/stc_sync.sv
`timescale 1ns/1ns
`default_nettype none
// two flip-flop synchroniser for pin levels
module stc_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             mclk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] asyncIn,
    input  wire logic [WIDTH-1:0] resetVal,
    output var  logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] hold_reg;

    initial
    begin
        if (WIDTH < 1) $error("stc_sync width");
    end

    // first stage is read only by the second
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_reg <= '0;
            hold_reg <= '0;
        end
        else
        begin
            meta_reg <= asyncIn ^ resetVal;
            hold_reg <= meta_reg;
        end
    end

    // stored relative to the idle level, so reset shows the idle level
    assign syncOut = hold_reg ^ resetVal;
endmodule
`default_nettype wire

//--- rtl/stc_div.sv
`timescale 1ns/1ns
`default_nettype none
// half period tick generator for master serial clock
module stc_div #(
    parameter int DW = 8
) (
    input  wire logic          mclk,
    input  wire logic          rst_n,
    input  wire logic          run,
    input  wire logic [DW-1:0] halfCount,
    output var  logic          tick
);
    logic [DW-1:0] cnt_reg;

    initial
    begin
        if (DW < 2) $error("stc_div width");
    end

    // counts mclk cycles, tick once per half serial period
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_reg <= '0;
            tick    <= 1'b0;
        end
        else if (!run || cnt_reg >= halfCount)
        begin
            cnt_reg <= '0;
            tick    <= run;
        end
        else
        begin
            cnt_reg <= cnt_reg + 1'b1;
            tick    <= 1'b0;
        end
    end
endmodule
`default_nettype wire

//--- rtl/stc_spi_core.sv
`include "stc_map.svh"
`timescale 1ns/1ns
`default_nettype none
module stc_spi_core
    import stc_pkg::*;
(
    input  wire logic                      mclk,
    input  wire logic                      rst_n,
    input  wire stc_pkg::stc_wb_req_type   wbReq,
    output var  logic [31:0]               wbDatO,
    output logic                           wbAck,
    input  wire logic                      sckIn,
    input  wire logic                      mosiIn,
    input  wire logic                      misoIn,
    input  wire logic                      ssNIn,
    output var  stc_pkg::stc_pins_out_type pins,
    output logic                           irq
);
    import stc_pkg::*;

    logic [7:0]    ctrl1_reg;
    logic [7:0]    ctrl2_reg;
    logic [7:0]    div_reg;
    logic [7:0]    txBuf_reg;
    logic [7:0]    rxBuf_reg;
    logic [7:0]    shift_reg;
    logic          txEmpty_reg;
    logic          txFull_reg;
    logic          rxFull_reg;
    logic          mode_fault_flag_reg;
    logic          seenTx_reg;
    logic          seenRx_reg;
    logic          seenModf_reg;
    logic          ack_reg;
    stc_state_type state_reg;
    logic [4:0]    half_reg;
    logic          sck_reg;
    logic          ssOut_reg;
    logic          sampled_reg;
    logic [3:0]    sync;
    logic          sckS;
    logic          mosiS;
    logic          misoS;
    logic          ssNS;
    logic          sckPrev_reg;
    logic          ssPrev_reg;
    logic          tick;
    logic          busy;
    logic          access;
    logic          wrStb;
    logic          rdStb;
    logic          isMaster;
    logic          cpha;
    logic          cpol;
    logic          lsbFirst;
    logic          enabled;
    logic          ssOutMode;
    logic          faultIn;
    logic          doneNow;
    logic          startNow;
    logic          slaveLead;
    logic          slaveTrail;
    logic          slaveStart;
    logic          outBit;
    logic          inBit;
    logic          sampleEv;
    logic          shiftEv;
    logic [7:0]    sideIn;
    logic          inNow;

    assign isMaster  = ctrl1_reg[`STC_C1_MASTER_SELECT];
    assign cpha      = ctrl1_reg[`STC_C1_CPHA];
    assign cpol      = ctrl1_reg[`STC_C1_CPOL];
    assign lsbFirst  = ctrl1_reg[`STC_C1_LSB_FIRST_SELECT];
    assign enabled   = ctrl1_reg[`STC_C1_EN];
    assign ssOutMode = ctrl2_reg[`STC_C2_FAULT_ENABLE] & ctrl1_reg[`STC_C1_SELECT_OUTPUT_ENABLE];
    assign busy      = (state_reg != STC_IDLE);

    // pin inputs through two flops
    stc_sync #(.WIDTH(4)) uSync (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .asyncIn  ({sckIn, mosiIn, misoIn, ssNIn}),
        .resetVal (4'h1),
        .syncOut  (sync)
    );
    assign {sckS, mosiS, misoS, ssNS} = sync;

    // master half period ticks
    stc_div #(.DW(8)) uDiv (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .run       (busy & isMaster),
        .halfCount (div_reg),
        .tick      (tick)
    );

    // wishbone classic decode, one wait state
    assign access = wbReq.cyc & wbReq.stb & ~ack_reg;
    assign wrStb  = access & wbReq.we & wbReq.sel[0];
    assign rdStb  = access & ~wbReq.we;
    assign wbAck  = ack_reg;

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            ack_reg <= 1'b0;
        else
            ack_reg <= access;
    end

    // read data mux, unmapped reads zero
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            wbDatO <= '0;
        else if (rdStb)
        begin
            unique case (wbReq.adr)
                `STC_OFS_CTRL1:  wbDatO <= {24'h0, ctrl1_reg};
                `STC_OFS_STATUS: wbDatO <= {24'h0, rxFull_reg, 1'b0, txEmpty_reg,
                                            mode_fault_flag_reg, 4'h0};
                `STC_OFS_DATA:   wbDatO <= {24'h0, rxBuf_reg};
                `STC_OFS_DIV:    wbDatO <= {24'h0, div_reg};
                default:         wbDatO <= '0;
            endcase
        end
    end

    // fault input only in its qualified mode
    assign faultIn = isMaster & ctrl2_reg[`STC_C2_FAULT_ENABLE]
                   & ~ctrl1_reg[`STC_C1_SELECT_OUTPUT_ENABLE] & ~ssNS;

    // control registers; fault drops master bit
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl1_reg <= `STC_CTRL1_RST;
            ctrl2_reg <= `STC_CTRL2_RST;
            div_reg   <= `STC_DIV_RST;
        end
        else
        begin
            if (wrStb && wbReq.adr == `STC_OFS_CTRL1)
                ctrl1_reg <= wbReq.dat;
            if (wrStb && wbReq.adr == `STC_OFS_DIV)
                ctrl1_reg <= ctrl1_reg;
            if (wrStb && wbReq.adr == `STC_OFS_DIV)
                div_reg <= wbReq.dat;
            if (wrStb && wbReq.adr == `STC_OFS_CTRL2)
                ctrl2_reg <= wbReq.dat;
            if (faultIn)
                ctrl1_reg[`STC_C1_MASTER_SELECT] <= 1'b0;
        end
    end

    // mode fault flag: set wins over clear
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mode_fault_flag_reg     <= 1'b0;
            seenModf_reg <= 1'b0;
        end
        else if (faultIn)
        begin
            mode_fault_flag_reg     <= 1'b1;
            seenModf_reg <= 1'b0;
        end
        else if (rdStb && wbReq.adr == `STC_OFS_STATUS && mode_fault_flag_reg)
            seenModf_reg <= 1'b1;
        else if (wrStb && wbReq.adr == `STC_OFS_CTRL1 && seenModf_reg)
        begin
            mode_fault_flag_reg     <= 1'b0;
            seenModf_reg <= 1'b0;
        end
    end

    // slave select edges and clock edges seen by the slave
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sckPrev_reg <= 1'b0;
            ssPrev_reg  <= 1'b1;
        end
        else
        begin
            sckPrev_reg <= sckS;
            ssPrev_reg  <= ssNS;
        end
    end
    assign slaveLead  = (sckS ^ sckPrev_reg) & ((sckS ^ cpol) ^ cpha);
    assign slaveTrail = (sckS ^ sckPrev_reg) & ~((sckS ^ cpol) ^ cpha);
    assign slaveStart = ~isMaster & enabled & ~ssNS & (ssPrev_reg | ~busy);

    // with cpha 0 sample on the leading clock edge and shift on the trailing one; with cpha 1 shift on the leading edge, sample on the trailing
    assign sampleEv = isMaster ? (tick & (half_reg[0] == cpha) & (state_reg == STC_SHIFT))
                               : (slaveLead & ~ssNS & busy);
    assign shiftEv  = isMaster ? (tick & (half_reg[0] != cpha) & (state_reg == STC_SHIFT))
                               : (slaveTrail & ~ssNS & busy);
    assign inBit    = isMaster ? misoS : mosiS;
    assign outBit   = lsbFirst ? shift_reg[0] : shift_reg[7];
    // last bit of a phase one byte is taken straight from the pin
    assign inNow    = sampleEv ? inBit : sampled_reg;
    assign sideIn   = lsbFirst ? {inNow, shift_reg[7:1]}
                               : {shift_reg[6:0], inNow};
    assign doneNow  = (sampleEv | shiftEv) & (half_reg == `STC_HALVES - 5'h1);
    assign startNow = ~busy & txFull_reg & isMaster & enabled;

    // transfer sequencer
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg   <= STC_IDLE;
            half_reg    <= '0;
            shift_reg   <= '0;
            sampled_reg <= 1'b0;
            sck_reg     <= 1'b0;
            ssOut_reg   <= 1'b1;
        end
        else if (faultIn || !enabled || (!isMaster && busy && ssNS && !ssPrev_reg
                 && !cpha))
        begin
            state_reg <= STC_IDLE;
            half_reg  <= '0;
            sck_reg   <= 1'b0;
            ssOut_reg <= 1'b1;
        end
        else
        begin
            if (startNow || (slaveStart && !busy))
            begin
                shift_reg <= startNow ? txBuf_reg : (txFull_reg ? txBuf_reg : shift_reg);
                half_reg  <= '0;
                ssOut_reg <= 1'b0;
                state_reg <= (startNow && cpha) ? STC_LEAD : STC_SHIFT;
            end
            else if (isMaster && tick)
            begin
                unique case (state_reg)
                    STC_LEAD:  state_reg <= STC_SHIFT;
                    STC_SHIFT:
                    begin
                        sck_reg  <= ~sck_reg;
                        half_reg <= half_reg + 5'h1;
                        if (doneNow)
                            state_reg <= cpha ? STC_IDLE : STC_TAIL;
                        if (cpha && doneNow)
                            ssOut_reg <= 1'b1;
                    end
                    STC_TAIL:
                    begin
                        state_reg <= STC_IDLE;
                        ssOut_reg <= 1'b1;
                    end
                    STC_IDLE:  state_reg <= STC_IDLE;
                endcase
            end
            else if (!isMaster && (sampleEv || shiftEv))
            begin
                half_reg <= half_reg + 5'h1;
                if (doneNow)
                    state_reg <= cpha ? STC_LEAD : STC_IDLE;
            end
            else if (!isMaster && state_reg == STC_LEAD)
                state_reg <= STC_SHIFT;
            if (sampleEv)
                sampled_reg <= inBit;
            if (shiftEv && !(cpha && half_reg == 5'h0))
                shift_reg <= sideIn;
        end
    end

    // transmit buffer and empty flag
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            txBuf_reg   <= '0;
            txFull_reg  <= 1'b0;
            txEmpty_reg <= 1'b1;
            seenTx_reg  <= 1'b0;
        end
        else
        begin
            if (rdStb && wbReq.adr == `STC_OFS_STATUS)
                seenTx_reg <= txEmpty_reg;
            if (wrStb && wbReq.adr == `STC_OFS_DATA && seenTx_reg && txEmpty_reg)
            begin
                txBuf_reg   <= wbReq.dat;
                txFull_reg  <= 1'b1;
                txEmpty_reg <= 1'b0;
                seenTx_reg  <= 1'b0;
            end
            else if (startNow || (slaveStart && !busy && txFull_reg))
            begin
                txFull_reg  <= 1'b0;
                txEmpty_reg <= 1'b1;
            end
        end
    end

    // receive buffer: overrun drops new byte silently
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rxBuf_reg  <= '0;
            rxFull_reg <= 1'b0;
            seenRx_reg <= 1'b0;
        end
        else if (doneNow && !rxFull_reg)
        begin
            rxBuf_reg  <= sideIn;
            rxFull_reg <= 1'b1;
        end
        else if (rdStb && wbReq.adr == `STC_OFS_STATUS)
            seenRx_reg <= rxFull_reg;
        else if (rdStb && wbReq.adr == `STC_OFS_DATA && seenRx_reg && rxFull_reg)
        begin
            rxFull_reg <= 1'b0;
            seenRx_reg <= 1'b0;
        end
        // full buffer keeps old byte, no flag
    end

    // master pin drivers, disabled when not master or after fault; miso driven only as a selected slave
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            pins <= '{sck: 1'b0, sckOe: 1'b0, mosi: 1'b0, mosiOe: 1'b0,
                      miso: 1'b0, misoOe: 1'b0, ssN: 1'b1, ssNOe: 1'b0};
        else
        begin
            pins.sck    <= sck_reg ^ cpol;
            pins.sckOe  <= enabled & isMaster & ~faultIn;
            pins.mosi   <= outBit;
            pins.mosiOe <= enabled & isMaster & ~faultIn;
            pins.miso   <= outBit;
            pins.misoOe <= enabled & ~isMaster & ~ssNS;
            pins.ssN    <= ssOut_reg;
            pins.ssNOe  <= enabled & isMaster & ssOutMode;
        end
    end

    // interrupt request from masked flags
    assign irq = (ctrl1_reg[`STC_C1_RXIE] & (rxFull_reg | mode_fault_flag_reg))
               | (ctrl1_reg[`STC_C1_TXIE] & txEmpty_reg);
endmodule
`default_nettype wire

//--- verif/stc_spi_core_sva.sv
`timescale 1ns/1ns
`default_nettype none
// bus answer and pin driver checks
module stc_spi_core_sva
    import stc_pkg::*;
(
    input wire logic                      mclk,
    input wire logic                      rst_n,
    input wire stc_pkg::stc_wb_req_type   wbReq,
    input wire logic [31:0]               wbDatO,
    input wire logic                      wbAck,
    input wire stc_pkg::stc_pins_out_type pins,
    input wire logic                      irq
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    wire logic req = wbReq.cyc && wbReq.stb;
    // one cycle answer to a taken request
    sequence s_take;
        req && !wbAck;
    endsequence
    sequence s_answer;
        wbAck ##1 !wbAck;
    endsequence
    property p_ack_resp;
        s_take |=> s_answer;
    endproperty
    a_ack_resp: assert property (p_ack_resp)
        else $error("ack late or held");
    property p_ack_cause;
        !req |=> !wbAck;
    endproperty
    a_ack_cause: assert property (p_ack_cause)
        else $error("ack without request");
    property p_ack_bound;
        req |-> ##[0:1] wbAck;
    endproperty
    a_ack_bound: assert property (p_ack_bound)
        else $error("request not answered");
    property p_dat_hold;
        $changed(wbDatO) |-> $past(req && !wbReq.we && !wbAck);
    endproperty
    a_dat_hold: assert property (p_dat_hold)
        else $error("read data moved without read");
    property p_reset_idle;
        $rose(rst_n) |-> !pins.sckOe && !pins.mosiOe && !irq;
    endproperty
    a_reset_idle: assert property (p_reset_idle)
        else $error("not idle after reset");
    property p_oe_pair;
        pins.sckOe == pins.mosiOe;
    endproperty
    a_oe_pair: assert property (p_oe_pair)
        else $error("clock and data drivers differ");
    property p_one_role;
        !(pins.sckOe && pins.misoOe);
    endproperty
    a_one_role: assert property (p_one_role)
        else $error("master and slave drivers both on");
    property p_sck_owner;
        $changed(pins.sck) |-> pins.sckOe || $past(pins.sckOe);
    endproperty
    a_sck_owner: assert property (p_sck_owner)
        else $error("clock moved while not driven");
endmodule
bind stc_spi_core stc_spi_core_sva u_sva (.mclk(mclk), .rst_n(rst_n), .wbReq(wbReq),
    .wbDatO(wbDatO), .wbAck(wbAck), .pins(pins), .irq(irq));
`default_nettype wire

//--- verif/stc_spi_slave.sv
`timescale 1ns/1ns
`default_nettype none
// behavioural slave; odd frames send the inverted byte
module stc_spi_slave (
    input  wire logic       sck,
    input  wire logic       mosi,
    input  wire logic       selN,
    input  wire logic       cpol,
    input  wire logic       cpha,
    input  wire logic       lsbFirst,
    input  wire logic [7:0] txByte,
    output var  logic       miso,
    output var  logic [7:0] rxByte,
    output var  int         doneCnt
);
    int         bitIn = 0;
    int         bitOut = 0;
    logic [7:0] txCur = 8'h00;
    logic [7:0] rxSh = 8'h00;
    initial miso = 1'b0;
    initial rxByte = 8'h00;
    initial doneCnt = 0;
    // wire position of the k-th bit
    function automatic int pos(input int k);
        return lsbFirst ? k : 7 - k;
    endfunction
    // select starts a frame, release leaves the inverse level
    always @(selN)
    begin
        bitIn = 0;
        bitOut = 0;
        txCur = doneCnt[0] ? ~txByte : txByte;
        if (selN)
            miso = ~miso;
        else if (!cpha)
        begin
            miso = txCur[pos(0)];
            bitOut = 1;
        end
    end
    // launch on one edge, sample on the other
    always @(sck)
    begin
        if (!selN && ((sck != cpol) == cpha))
        begin
            if (bitOut == 8)
            begin
                bitOut = 0;
                txCur = doneCnt[0] ? ~txByte : txByte;
            end
            miso = txCur[pos(bitOut)];
            bitOut++;
        end
        else if (!selN)
        begin
            rxSh[pos(bitIn)] = mosi;
            bitIn++;
            if (bitIn == 8)
            begin
                rxByte = rxSh;
                doneCnt++;
                bitIn = 0;
            end
        end
    end
endmodule
`default_nettype wire

//--- verif/test_spi_transfer_core.sv
`include "stc_map.svh"
`timescale 1ns/1ns
`default_nettype none
module test_spi_transfer_core;
    import stc_pkg::*;
    logic             mclk;
    logic             rst_n;
    logic             wbAck;
    logic             irq;
    logic             miso;
    logic             selN;
    logic             cpol;
    logic             cpha;
    logic             lsb;
    logic [31:0]      wbDatO;
    logic [7:0]       slvTx;
    logic [7:0]       slvRx;
    logic [7:0]       rd;
    logic [7:0]       txv;
    logic [7:0]       ex;
    stc_wb_req_type   wbReq;
    stc_pins_out_type pins;
    int               doneCnt;
    int               cnt;
    int               error_cnt = 0;
    int               num_checks = 0;
    stc_spi_core u_dut (.mclk(mclk), .rst_n(rst_n), .wbReq(wbReq), .wbDatO(wbDatO),
        .wbAck(wbAck), .sckIn(1'b0), .mosiIn(1'b0), .misoIn(miso), .ssNIn(1'b1),
        .pins(pins), .irq(irq));
    stc_spi_slave u_slv (.sck(pins.sck), .mosi(pins.mosi), .selN(selN), .cpol(cpol),
        .cpha(cpha), .lsbFirst(lsb), .txByte(slvTx), .miso(miso), .rxByte(slvRx),
        .doneCnt(doneCnt));
    // 50 MHz clock
    initial
    begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    // verdict and end of run
    task results;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task hang;
        check("wait", 8'h00, 8'h01);
        results;
    endtask
    // one classic wishbone cycle, read data lands in rd
    task bus(input logic we, input logic [3:0] adr, input logic [7:0] dat);
        int i;
        @(posedge mclk);
        wbReq <= '{1'b1, 1'b1, we, adr, 4'h1, dat};
        for (i = 0; i < 20; i++)
        begin
            @(posedge mclk);
            if (wbAck === 1'b1)
                break;
        end
        if (i == 20)
            hang;
        rd = wbDatO[7:0];
        wbReq <= '0;
    endtask
    // poll status until a byte has arrived
    task wait_rx;
        int i;
        for (i = 0; i < 60; i++)
        begin
            bus(1'b0, `STC_OFS_STATUS, 8'h00);
            if (rd[7] === 1'b1)
                break;
        end
        if (i == 60)
            hang;
    endtask
    task wait_done(input int n);
        int i;
        for (i = 0; i < 400 && doneCnt != n; i++)
            @(posedge mclk);
        if (i == 400)
            hang;
    endtask
    // main sequence
    initial
    begin
        rst_n = 1'b0;
        wbReq = '0;
        selN = 1'b1;
        {cpol, cpha, lsb} = 3'b000;
        slvTx = 8'h00;
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        bus(1'b0, `STC_OFS_STATUS, 8'h00);
        check("status", rd, 8'h20);
        check("irq", {7'h00, irq}, 8'h00);
        bus(1'b0, `STC_OFS_CTRL1, 8'h00);
        check("ctrl1", rd, `STC_CTRL1_RST);
        bus(1'b0, `STC_OFS_DIV, 8'h00);
        check("div", rd, `STC_DIV_RST);
        bus(1'b0, 4'h2, 8'h00);
        bus(1'b1, `STC_OFS_DIV, 8'h03);
        $display("test reset done");
        // every clock format, both bit orders; unarmed second write
        for (int m = 0; m < 8; m++)
        begin
            {lsb, cpha, cpol} = m[2:0];
            slvTx = 8'hc6 ^ m[7:0];
            txv = 8'hb4 ^ m[7:0];
            ex = doneCnt[0] ? ~slvTx : slvTx;
            bus(1'b1, `STC_OFS_CTRL1, {4'h7, cpol, cpha, 1'b0, lsb});
            check("irq", {7'h00, irq}, 8'h01);
            @(posedge mclk) selN <= 1'b0;
            bus(1'b0, `STC_OFS_STATUS, 8'h00);
            bus(1'b1, `STC_OFS_DATA, txv);
            bus(1'b1, `STC_OFS_DATA, ~txv);
            wait_rx;
            check("slave rx", slvRx, txv);
            bus(1'b0, `STC_OFS_DATA, 8'h00);
            check("data", rd, ex);
            bus(1'b0, `STC_OFS_STATUS, 8'h00);
            check("status", rd, 8'h20);
            repeat (70) @(posedge mclk);
            check("frames", doneCnt[7:0], m[7:0] + 8'h01);
            check("sck idle", {7'h00, pins.sck}, {7'h00, cpol});
            @(posedge mclk) selN <= 1'b1;
        end
        $display("test formats done");
        // queued byte runs on its own, second byte overruns
        {lsb, cpha, cpol} = 3'b010;
        slvTx = 8'h96;
        bus(1'b1, `STC_OFS_CTRL1, 8'h54);
        check("irq", {7'h00, irq}, 8'h00);
        @(posedge mclk) selN <= 1'b0;
        cnt = doneCnt;
        ex = doneCnt[0] ? ~slvTx : slvTx;
        bus(1'b0, `STC_OFS_STATUS, 8'h00);
        bus(1'b1, `STC_OFS_DATA, 8'h5a);
        bus(1'b0, `STC_OFS_STATUS, 8'h00);
        check("tx empty", rd & 8'h20, 8'h20);
        bus(1'b1, `STC_OFS_DATA, 8'ha7);
        wait_done(cnt + 2);
        check("slave rx", slvRx, 8'ha7);
        repeat (20) @(posedge mclk);
        bus(1'b1, `STC_OFS_CTRL1, 8'hd4);
        check("irq", {7'h00, irq}, 8'h01);
        bus(1'b0, `STC_OFS_STATUS, 8'h00);
        check("status", rd, 8'ha0);
        bus(1'b0, `STC_OFS_DATA, 8'h00);
        check("data", rd, ex);
        check("irq", {7'h00, irq}, 8'h00);
        @(posedge mclk) selN <= 1'b1;
        $display("test overrun done");
        results;
    end
endmodule
`default_nettype wire
